// >>> pkg/ign_status_pkg.sv
// Constants, state encoding and status codes for the ignition status sequencer.
// Assumes a 100 MHz system clock.
package ign_status_pkg;
   localparam int CLOCK_HZ = 100_000_000;
   // Standstill timeout in milliseconds, and its cycle count
   localparam int STANDSTILL_MS = 500;
   localparam int STANDSTILL_CYCLES = STANDSTILL_MS * (CLOCK_HZ / 1000);
   localparam int TIMER_WIDTH = 32;
   // Host link watchdog: no heartbeat within this time drops the connection
   localparam int LINK_TIMEOUT_MS = 100;
   localparam int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_MS * (CLOCK_HZ / 1000);
   localparam int SYNC_INPUTS = 13;
   localparam logic [3:0] STATUS_RESET = 4'h0;

   typedef enum logic [10:0] {
      ST_INIT        = 11'h001,
      ST_READY       = 11'h002,
      ST_CONFIG      = 11'h004,
      ST_SELFTEST    = 11'h008,
      ST_SYNC        = 11'h010,
      ST_LOCKED      = 11'h020,
      ST_ACTIVE      = 11'h040,
      ST_WAIT_STOP   = 11'h080,
      ST_OP_ERROR    = 11'h100,
      ST_SYS_ERROR   = 11'h200,
      ST_HALT        = 11'h400
   } state_type;

   // Status codes seen by host and panel
   localparam logic [3:0] CODE_INIT = 4'h0;
   localparam logic [3:0] CODE_READY = 4'h1;
   localparam logic [3:0] CODE_CONFIG = 4'h2;
   localparam logic [3:0] CODE_SELFTEST = 4'h3;
   localparam logic [3:0] CODE_SYNC = 4'h4;
   localparam logic [3:0] CODE_LOCKED = 4'h5;
   localparam logic [3:0] CODE_ACTIVE = 4'h6;
   localparam logic [3:0] CODE_WAIT_STOP = 4'h7;
   localparam logic [3:0] CODE_OP_ERROR = 4'h8;
   localparam logic [3:0] CODE_SYS_ERROR = 4'h9;
   localparam logic [3:0] CODE_HALT = 4'hf;
endpackage

// >>> pkg/pickup_if.sv
// Pickup activity bundle passed between the sequencer and its standstill monitor.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface pickup_if;
   logic edge_seen;
   logic standstill;
   modport monitor (input edge_seen, output standstill);
   modport sequencer (output edge_seen, input standstill);
endinterface
`default_nettype wire

// >>> hdl/sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/10ps
`default_nettype none
module sync2 (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic async_in,
   output logic sync_out
);
   logic stage;
   // First stage is read by the second stage only
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage <= async_in;
         sync_out <= stage;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/standstill_monitor.sv
// Standstill detector: flags standstill when no pickup edge arrives in time.
// Assumes edge_seen is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
`default_nettype none
module standstill_monitor
   import ign_status_pkg::*;
#(
   parameter logic [TIMER_WIDTH-1:0] TIMEOUT = TIMER_WIDTH'(STANDSTILL_CYCLES)
) (
   input wire logic clock,
   input wire logic arst_n,
   pickup_if.monitor pick
);
   logic [TIMER_WIDTH-1:0] idle_count;
   // Count idle cycles; any edge restarts the wait
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         idle_count <= '0;
         pick.standstill <= 1'b1;
      end else if (pick.edge_seen) begin
         idle_count <= '0;
         pick.standstill <= 1'b0;
      end else if (idle_count >= TIMEOUT - 1'b1) begin
         pick.standstill <= 1'b1;
      end else begin
         idle_count <= idle_count + 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/ignition_status_sequencer.sv
// Operating status state machine of the ignition controller.
// Assumes all command and event inputs are asynchronous levels or pulses
// wide enough to survive two-flop synchronisation.
`timescale 1ns/10ps
`default_nettype none
module ignition_status_sequencer
   import ign_status_pkg::*;
#(
   parameter logic [TIMER_WIDTH-1:0] STANDSTILL_TIMEOUT = TIMER_WIDTH'(STANDSTILL_CYCLES),
   parameter logic [TIMER_WIDTH-1:0] LINK_TIMEOUT = TIMER_WIDTH'(LINK_TIMEOUT_CYCLES)
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic INIT_DONE,
   input wire logic INIT_FAIL,
   input wire logic HOST_LINK_ALIVE,
   input wire logic HOST_CONFIG_START,
   input wire logic HOST_CONFIG_END,
   input wire logic CONFIG_PLAUSIBLE,
   input wire logic HOST_TEST_CMD,
   input wire logic PANEL_TEST_CMD,
   input wire logic HOST_ACK,
   input wire logic PANEL_ACK,
   input wire logic PICKUP_EDGE,
   input wire logic CAM_EVENT,
   input wire logic REV_COMPLETE,
   input wire logic PICKUP_ERROR,
   input wire logic IGNITION_RELEASE,
   input wire logic ABOVE_SECURITY_SPEED,
   input wire logic OVERSPEED,
   input wire logic SEVERE_FAULT,
   output logic IGNITION_ENABLE,
   output logic PICKUP_EVAL_ENABLE,
   output logic CONFIG_WRITE_ENABLE,
   output logic CONFIG_COMMIT,
   output logic CONFIG_RESTORE,
   output logic SELF_TEST_RUN,
   output logic CRITICAL_LED,
   output logic MONITOR_ENABLE,
   output logic [3:0] STATUS
);
   logic [SYNC_INPUTS-1:0] raw_in;
   logic [SYNC_INPUTS-1:0] sync_in;
   logic [SYNC_INPUTS-1:0] prev_in;
   logic [SYNC_INPUTS-1:0] rise;
   logic init_done, init_fail, link_alive, cfg_start, cfg_end, plausible;
   logic test_cmd_h, test_cmd_p, ack_h, ack_p;
   logic pickup_lvl, cam_lvl, rev_lvl, pick_err, release_lvl, fast, over, severe;
   logic test_toggle, ack_cmd, cam_seen, link_lost, fault;
   logic [TIMER_WIDTH-1:0] link_count;
   state_type state, next_state;
   pickup_if pick ();

   // Every pin passes two flops before any decision reads it
   assign raw_in = {SEVERE_FAULT, OVERSPEED, ABOVE_SECURITY_SPEED, IGNITION_RELEASE,
                    PICKUP_ERROR, REV_COMPLETE, CAM_EVENT, PICKUP_EDGE,
                    PANEL_ACK, HOST_ACK, PANEL_TEST_CMD, HOST_TEST_CMD, HOST_CONFIG_END};
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_INPUTS; gi++) begin : g_sync
         sync2 u_sync (
            .clock(CLOCK),
            .arst_n(ARST_N),
            .async_in(raw_in[gi]),
            .sync_out(sync_in[gi])
         );
      end
   endgenerate
   // Plain levels that never pass the rise detector still get two flops each
   sync2 u_sync_done (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .async_in(INIT_DONE),
      .sync_out(init_done)
   );
   sync2 u_sync_fail (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .async_in(INIT_FAIL),
      .sync_out(init_fail)
   );
   sync2 u_sync_link (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .async_in(HOST_LINK_ALIVE),
      .sync_out(link_alive)
   );
   sync2 u_sync_cfgs (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .async_in(HOST_CONFIG_START),
      .sync_out(cfg_start)
   );
   sync2 u_sync_plau (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .async_in(CONFIG_PLAUSIBLE),
      .sync_out(plausible)
   );

   // Edge history so commands act once per press, not once per cycle held
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_in <= '0;
      end else begin
         prev_in <= sync_in;
      end
   end
   assign rise = sync_in & ~prev_in;

   // Commands and pickup events act once, on their rising edge
   assign cfg_end = rise[0];
   assign test_cmd_h = rise[1];
   assign test_cmd_p = rise[2];
   assign ack_h = rise[3];
   assign ack_p = rise[4];
   assign pickup_lvl = rise[5];
   assign cam_lvl = rise[6];
   assign rev_lvl = rise[7];
   // Faults and release act as levels, so a held fault keeps acting
   assign pick_err = sync_in[8];
   assign release_lvl = sync_in[9];
   assign fast = sync_in[10];
   assign over = sync_in[11];
   assign severe = sync_in[12];
   assign test_toggle = test_cmd_h | test_cmd_p;
   assign ack_cmd = ack_h | ack_p;
   assign fault = pick_err | over;

   // Pickup edges feed the standstill monitor
   assign pick.edge_seen = pickup_lvl;
   standstill_monitor #(
      .TIMEOUT(STANDSTILL_TIMEOUT)
   ) u_standstill (
      .clock(CLOCK),
      .arst_n(ARST_N),
      .pick(pick)
   );

   // Host link watchdog: the heartbeat level must not stay low for LINK_TIMEOUT cycles
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         link_count <= '0;
         link_lost <= 1'b0;
      end else if (link_alive) begin
         link_count <= '0;
         link_lost <= 1'b0;
      end else if (link_count >= LINK_TIMEOUT - 1'b1) begin
         link_lost <= 1'b1;
      end else begin
         link_count <= link_count + 1'b1;
      end
   end

   // Camshaft mark is remembered until the sequencer leaves sync
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         cam_seen <= 1'b0;
      end else if (state != ST_SYNC) begin
         cam_seen <= 1'b0;
      end else if (cam_lvl) begin
         cam_seen <= 1'b1;
      end
   end

   // Next state; severe fault outranks everything else except halt
   always_comb begin
      next_state = state;
      if (severe && state != ST_HALT) begin
         next_state = ST_SYS_ERROR;
      end else begin
         unique case (state)
            ST_INIT: begin
               if (init_fail) begin
                  next_state = ST_HALT;
               end else if (init_done) begin
                  next_state = ST_READY;
               end
            end
            ST_READY: begin
               if (cfg_start && !link_lost) begin
                  next_state = ST_CONFIG;
               end else if (test_toggle) begin
                  next_state = ST_SELFTEST;
               end else if (pickup_lvl) begin
                  next_state = ST_SYNC;
               end
            end
            ST_CONFIG: begin
               // Pickup edges are not looked at here
               if (cfg_end || link_lost) begin
                  next_state = ST_READY;
               end
            end
            ST_SELFTEST: begin
               if (pickup_lvl) begin
                  next_state = ST_OP_ERROR;
               end else if (test_toggle) begin
                  next_state = ST_READY;
               end
            end
            ST_SYNC: begin
               if (over) begin
                  next_state = ST_OP_ERROR;
               end else if (pick_err || pick.standstill) begin
                  next_state = fast ? ST_OP_ERROR : ST_SYNC;
               end else if (cam_seen && rev_lvl) begin
                  next_state = release_lvl ? ST_ACTIVE : ST_LOCKED;
               end
            end
            ST_LOCKED: begin
               if (over) begin
                  next_state = ST_OP_ERROR;
               end else if (pick_err || pick.standstill) begin
                  next_state = fast ? ST_OP_ERROR : ST_SYNC;
               end else if (release_lvl) begin
                  next_state = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               // Security speed decides whether a withdrawal may resume at once
               if (over) begin
                  next_state = ST_OP_ERROR;
               end else if (pick_err || pick.standstill) begin
                  next_state = fast ? ST_OP_ERROR : ST_SYNC;
               end else if (!release_lvl) begin
                  next_state = fast ? ST_WAIT_STOP : ST_LOCKED;
               end
            end
            ST_WAIT_STOP: begin
               if (fault) begin
                  next_state = ST_OP_ERROR;
               end else if (pick.standstill) begin
                  next_state = ST_READY;
               end
            end
            ST_OP_ERROR: begin
               // Acknowledge counts only once the engine is at rest
               if (ack_cmd && pick.standstill) begin
                  next_state = ST_READY;
               end
            end
            ST_SYS_ERROR: begin
               next_state = ST_SYS_ERROR;
            end
            ST_HALT: begin
               next_state = ST_HALT;
            end
            default: begin
               next_state = ST_SYS_ERROR;
            end
         endcase
      end
   end

   // State register; reset lands in init so nothing fires before the checks
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_INIT;
      end else begin
         state <= next_state;
      end
   end

   // Outputs follow the next state so they change with the state itself
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         IGNITION_ENABLE <= 1'b0;
         PICKUP_EVAL_ENABLE <= 1'b0;
         CONFIG_WRITE_ENABLE <= 1'b0;
         SELF_TEST_RUN <= 1'b0;
         CRITICAL_LED <= 1'b0;
         MONITOR_ENABLE <= 1'b0;
      end else begin
         IGNITION_ENABLE <= (next_state == ST_ACTIVE);
         PICKUP_EVAL_ENABLE <= (next_state != ST_CONFIG);
         CONFIG_WRITE_ENABLE <= (next_state == ST_CONFIG);
         SELF_TEST_RUN <= (next_state == ST_SELFTEST);
         CRITICAL_LED <= (next_state == ST_HALT);
         MONITOR_ENABLE <= (next_state != ST_INIT) && (next_state != ST_HALT);
      end
   end

   // Leaving configuration adopts or rolls back the settings, except when a severe fault meets a plausible end
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         CONFIG_COMMIT <= 1'b0;
         CONFIG_RESTORE <= 1'b0;
      end else begin
         CONFIG_COMMIT <= (state == ST_CONFIG) && (next_state == ST_READY)
                          && cfg_end && !link_lost && plausible;
         CONFIG_RESTORE <= (state == ST_CONFIG) && (next_state != ST_CONFIG)
                           && !(cfg_end && !link_lost && plausible);
      end
   end

   // Status code; a lost link or halt still reads a fixed value
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         STATUS <= STATUS_RESET;
      end else begin
         unique case (next_state)
            ST_INIT: STATUS <= CODE_INIT;
            ST_READY: STATUS <= CODE_READY;
            ST_CONFIG: STATUS <= CODE_CONFIG;
            ST_SELFTEST: STATUS <= CODE_SELFTEST;
            ST_SYNC: STATUS <= CODE_SYNC;
            ST_LOCKED: STATUS <= CODE_LOCKED;
            ST_ACTIVE: STATUS <= CODE_ACTIVE;
            ST_WAIT_STOP: STATUS <= CODE_WAIT_STOP;
            ST_OP_ERROR: STATUS <= CODE_OP_ERROR;
            ST_SYS_ERROR: STATUS <= CODE_SYS_ERROR;
            ST_HALT: STATUS <= CODE_HALT;
            default: STATUS <= CODE_SYS_ERROR;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> test/host_panel_model.sv
// Host configuration tool and operator panel as seen from the sequencer pins.
// Assumes the bench calls its tasks from a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_panel_model (
   input wire logic CLOCK,
   output var logic HOST_LINK_ALIVE,
   output var logic HOST_CONFIG_START,
   output var logic CONFIG_PLAUSIBLE,
   output wire logic HOST_CONFIG_END,
   output wire logic HOST_TEST_CMD,
   output wire logic PANEL_TEST_CMD,
   output wire logic HOST_ACK,
   output wire logic PANEL_ACK
);
   logic [4:0] cmd = 5'h00;

   // Edge commands: end config, host test, panel test, host ack, panel ack
   assign HOST_CONFIG_END = cmd[0];
   assign HOST_TEST_CMD = cmd[1];
   assign PANEL_TEST_CMD = cmd[2];
   assign HOST_ACK = cmd[3];
   assign PANEL_ACK = cmd[4];

   initial begin
      HOST_LINK_ALIVE = 1'b1;
      HOST_CONFIG_START = 1'b0;
      CONFIG_PLAUSIBLE = 1'b0;
   end

   // Held four cycles each way so the two-flop inputs cannot miss an edge
   task automatic pulse(input int which);
      @(negedge CLOCK);
      cmd[which] = 1'b1;
      repeat (4) @(negedge CLOCK);
      cmd[which] = 1'b0;
      repeat (4) @(negedge CLOCK);
   endtask

   // Link loss is a dropped heartbeat level, not a command
   task automatic levels(input logic link, input logic start, input logic plaus);
      HOST_LINK_ALIVE = link;
      HOST_CONFIG_START = start;
      CONFIG_PLAUSIBLE = plaus;
   endtask
endmodule
`default_nettype wire

// >>> test/status_checker.sv
// Timing relations between the sequencer status and its enables.
// Assumes binding to the sequencer top with its port names.
`timescale 1ns/10ps
`default_nettype none
module status_checker
   import ign_status_pkg::*;
(
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic SEVERE_FAULT,
   input wire logic OVERSPEED,
   input wire logic IGNITION_ENABLE,
   input wire logic PICKUP_EVAL_ENABLE,
   input wire logic CONFIG_WRITE_ENABLE,
   input wire logic CONFIG_COMMIT,
   input wire logic CONFIG_RESTORE,
   input wire logic SELF_TEST_RUN,
   input wire logic CRITICAL_LED,
   input wire logic MONITOR_ENABLE,
   input wire logic [3:0] STATUS
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   // Inputs pass two flops before the state edge, so allow some slack
   sequence s_op_err_off;
      ##[2:4] (STATUS == CODE_OP_ERROR && !IGNITION_ENABLE);
   endsequence
   sequence s_cfg_left;
      STATUS != CODE_CONFIG && $past(STATUS) == CODE_CONFIG ##1 !(CONFIG_COMMIT || CONFIG_RESTORE);
   endsequence

   a_ign_only_active: assert property (IGNITION_ENABLE == (STATUS == CODE_ACTIVE))
      else $error("ignition enable outside firing active");
   a_cfg_write_only: assert property (CONFIG_WRITE_ENABLE == (STATUS == CODE_CONFIG))
      else $error("config write enable wrong");
   a_eval_off_cfg: assert property (STATUS == CODE_CONFIG |-> !PICKUP_EVAL_ENABLE)
      else $error("pickups evaluated in config");
   a_cfg_end_pulse: assert property ((CONFIG_COMMIT || CONFIG_RESTORE) |-> s_cfg_left)
      else $error("commit or restore misplaced");
   a_test_run_state: assert property (SELF_TEST_RUN == (STATUS == CODE_SELFTEST))
      else $error("self test run wrong");
   a_op_err_blocks: assert property (STATUS == CODE_OP_ERROR |->
      !IGNITION_ENABLE && !SELF_TEST_RUN && !CONFIG_WRITE_ENABLE)
      else $error("function not blocked in op error");
   a_overspeed_err: assert property ($rose(OVERSPEED) && STATUS == CODE_LOCKED && !SEVERE_FAULT
      |-> s_op_err_off)
      else $error("overspeed not reaching op error");
   a_severe_sys_err: assert property ($rose(SEVERE_FAULT) && STATUS != CODE_HALT
      |-> ##[2:4] (STATUS == CODE_SYS_ERROR && !IGNITION_ENABLE))
      else $error("severe fault not reaching sys error");
   a_sys_err_sticky: assert property (STATUS == CODE_SYS_ERROR |=> STATUS == CODE_SYS_ERROR)
      else $error("sys error left without restart");
   a_halt_led_on: assert property (STATUS == CODE_HALT |-> CRITICAL_LED && !MONITOR_ENABLE)
      else $error("halt without critical led");
endmodule
bind ignition_status_sequencer status_checker status_checker_i (.*);
`default_nettype wire

// >>> test/tb_top.sv
// Scenario bench for the ignition status sequencer.
// Assumes short standstill and link timeouts so waits stay brief.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import ign_status_pkg::*;
();
   logic CLOCK = 1'b0;
   logic ARST_N, INIT_DONE, INIT_FAIL, PICKUP_EDGE, CAM_EVENT, REV_COMPLETE, PICKUP_ERROR;
   logic IGNITION_RELEASE, ABOVE_SECURITY_SPEED, OVERSPEED, SEVERE_FAULT;
   wire logic HOST_LINK_ALIVE, HOST_CONFIG_START, HOST_CONFIG_END, CONFIG_PLAUSIBLE;
   wire logic HOST_TEST_CMD, PANEL_TEST_CMD, HOST_ACK, PANEL_ACK;
   logic IGNITION_ENABLE, PICKUP_EVAL_ENABLE, CONFIG_WRITE_ENABLE, CONFIG_COMMIT;
   logic CONFIG_RESTORE, SELF_TEST_RUN, CRITICAL_LED, MONITOR_ENABLE;
   logic [3:0] STATUS;
   int err_total = 0, checks = 0, commits = 0, restores = 0;
   logic pick_run = 1'b0;
   logic [2:0] pdiv = 3'h0;

   ignition_status_sequencer #(.STANDSTILL_TIMEOUT(32'h14), .LINK_TIMEOUT(32'h14))
      ignition_status_sequencer_i (.*);
   host_panel_model host_panel_model_i (.*);

   always #5 CLOCK = ~CLOCK;

   // Pickup edge every 8 cycles, well inside the 20-cycle standstill timeout
   always @(negedge CLOCK) begin
      pdiv <= pdiv + 3'h1;
      PICKUP_EDGE <= pick_run & pdiv[2];
   end

   // Commit and restore last one cycle, so count them as they pass
   always @(posedge CLOCK) begin
      if (CONFIG_COMMIT === 1'b1) commits++;
      if (CONFIG_RESTORE === 1'b1) restores++;
   end

   task automatic results;
      if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_status(input logic [3:0] code);
      int n;
      n = 0;
      while (STATUS !== code && n < 300) begin
         @(negedge CLOCK);
         n++;
      end
      check(STATUS, code, "status");
   endtask

   task automatic hold_status(input logic [3:0] code);
      repeat (8) @(negedge CLOCK);
      check(STATUS, code, "status held");
   endtask

   task automatic edge_pulse(ref logic s);
      @(negedge CLOCK);
      s = 1'b1;
      repeat (4) @(negedge CLOCK);
      s = 1'b0;
      repeat (4) @(negedge CLOCK);
   endtask

   task automatic sc_config;
      host_panel_model_i.levels(1'b1, 1'b1, 1'b0);
      wait_status(CODE_CONFIG);
      check(4'(CONFIG_WRITE_ENABLE), 4'h1, "config write");
      check(4'(PICKUP_EVAL_ENABLE), 4'h0, "pickup eval");
      host_panel_model_i.levels(1'b1, 1'b0, 1'b0);
      pick_run = 1'b1;
      hold_status(CODE_CONFIG);
      pick_run = 1'b0;
      host_panel_model_i.pulse(0);
      wait_status(CODE_READY);
      check(4'(restores), 4'h1, "restores");
      host_panel_model_i.levels(1'b1, 1'b1, 1'b1);
      wait_status(CODE_CONFIG);
      host_panel_model_i.levels(1'b1, 1'b0, 1'b1);
      host_panel_model_i.pulse(0);
      wait_status(CODE_READY);
      check(4'(commits), 4'h1, "commits");
      host_panel_model_i.levels(1'b1, 1'b1, 1'b1);
      wait_status(CODE_CONFIG);
      host_panel_model_i.levels(1'b0, 1'b0, 1'b1);
      wait_status(CODE_READY);
      // The restore pulse is counted one edge after the status turns
      @(negedge CLOCK);
      check(4'(restores), 4'h2, "restores");
      host_panel_model_i.levels(1'b1, 1'b0, 1'b0);
   endtask

   task automatic sc_selftest;
      host_panel_model_i.pulse(2);
      wait_status(CODE_SELFTEST);
      check(4'(SELF_TEST_RUN), 4'h1, "test run");
      host_panel_model_i.pulse(1);
      wait_status(CODE_READY);
      host_panel_model_i.pulse(1);
      wait_status(CODE_SELFTEST);
      pick_run = 1'b1;
      wait_status(CODE_OP_ERROR);
      host_panel_model_i.levels(1'b1, 1'b1, 1'b0);
      hold_status(CODE_OP_ERROR);
      host_panel_model_i.levels(1'b1, 1'b0, 1'b0);
      host_panel_model_i.pulse(3);
      hold_status(CODE_OP_ERROR);
      pick_run = 1'b0;
      repeat (30) @(negedge CLOCK);
      host_panel_model_i.pulse(4);
      wait_status(CODE_READY);
   endtask

   task automatic sc_firing;
      IGNITION_RELEASE = 1'b1;
      pick_run = 1'b1;
      wait_status(CODE_SYNC);
      edge_pulse(REV_COMPLETE);
      hold_status(CODE_SYNC);
      edge_pulse(CAM_EVENT);
      edge_pulse(REV_COMPLETE);
      wait_status(CODE_ACTIVE);
      check(4'(IGNITION_ENABLE), 4'h1, "ignition");
      IGNITION_RELEASE = 1'b0;
      wait_status(CODE_LOCKED);
      check(4'(IGNITION_ENABLE), 4'h0, "ignition");
      IGNITION_RELEASE = 1'b1;
      wait_status(CODE_ACTIVE);
      ABOVE_SECURITY_SPEED = 1'b1;
      IGNITION_RELEASE = 1'b0;
      wait_status(CODE_WAIT_STOP);
      check(4'(IGNITION_ENABLE), 4'h0, "ignition");
      hold_status(CODE_WAIT_STOP);
      pick_run = 1'b0;
      wait_status(CODE_READY);
      ABOVE_SECURITY_SPEED = 1'b0;
   endtask

   task automatic sc_loss;
      pick_run = 1'b1;
      wait_status(CODE_SYNC);
      edge_pulse(CAM_EVENT);
      edge_pulse(REV_COMPLETE);
      wait_status(CODE_LOCKED);
      pick_run = 1'b0;
      wait_status(CODE_SYNC);
      pick_run = 1'b1;
      edge_pulse(CAM_EVENT);
      edge_pulse(REV_COMPLETE);
      wait_status(CODE_LOCKED);
      PICKUP_ERROR = 1'b1;
      wait_status(CODE_SYNC);
      PICKUP_ERROR = 1'b0;
      edge_pulse(CAM_EVENT);
      edge_pulse(REV_COMPLETE);
      wait_status(CODE_LOCKED);
      OVERSPEED = 1'b1;
      wait_status(CODE_OP_ERROR);
      OVERSPEED = 1'b0;
      pick_run = 1'b0;
      repeat (30) @(negedge CLOCK);
      host_panel_model_i.pulse(3);
      wait_status(CODE_READY);
   endtask

   task automatic sc_severe;
      SEVERE_FAULT = 1'b1;
      wait_status(CODE_SYS_ERROR);
      check(4'(MONITOR_ENABLE), 4'h1, "monitor");
      host_panel_model_i.pulse(3);
      hold_status(CODE_SYS_ERROR);
   endtask

   task automatic sc_halt;
      ARST_N = 1'b0;
      SEVERE_FAULT = 1'b0;
      INIT_DONE = 1'b0;
      INIT_FAIL = 1'b1;
      repeat (2) @(negedge CLOCK);
      check(STATUS, CODE_INIT, "status in reset");
      ARST_N = 1'b1;
      wait_status(CODE_HALT);
      check(4'(CRITICAL_LED), 4'h1, "critical led");
      check(4'(MONITOR_ENABLE), 4'h0, "monitor");
   endtask

   initial begin
      ARST_N = 1'b0;
      INIT_DONE = 1'b0;
      INIT_FAIL = 1'b0;
      CAM_EVENT = 1'b0;
      REV_COMPLETE = 1'b0;
      PICKUP_ERROR = 1'b0;
      IGNITION_RELEASE = 1'b0;
      ABOVE_SECURITY_SPEED = 1'b0;
      OVERSPEED = 1'b0;
      SEVERE_FAULT = 1'b0;
      repeat (2) @(negedge CLOCK);
      ARST_N = 1'b1;
      INIT_DONE = 1'b1;
      wait_status(CODE_READY);
      sc_config();
      sc_selftest();
      sc_firing();
      sc_loss();
      sc_severe();
      sc_halt();
      results();
   end

   // About 400 cycles are expected; a hang stops well after that
   initial begin
      #300000;
      err_total++;
      results();
   end
endmodule
`default_nettype wire
